/* design/bru_cond.sv */
`timescale 1ns/1ps
`include "bru_map.svh"
module bru_cond (
    input wire bru_pkg::bru_cond_t cond,
    input wire logic [`BRU_XLEN-1:0] rs_val,
    input wire logic [`BRU_XLEN-1:0] rt_val,
    input wire logic coprocessor_zero_class_cond,
    output logic met
);

    // ****************************************
    // signed zero tests
    // ****************************************
    // sign bit plus a reduction keeps this off the adder path
    function automatic logic is_neg(input logic [`BRU_XLEN-1:0] v);
        return v[`BRU_XLEN-1];
    endfunction

    function automatic logic is_zero(input logic [`BRU_XLEN-1:0] v);
        return ~|v;
    endfunction

    // ****************************************
    // condition select
    // ****************************************
    always_comb begin
        unique case (cond)
            bru_pkg::COND_EQUAL: met = (rs_val == rt_val);
            bru_pkg::COND_NOT_EQUAL: met = (rs_val != rt_val);
            bru_pkg::COND_LE_ZERO: met = is_neg(rs_val) | is_zero(rs_val);
            bru_pkg::COND_GT_ZERO: met = ~is_neg(rs_val) & ~is_zero(rs_val);
            bru_pkg::COND_LT_ZERO: met = is_neg(rs_val);
            bru_pkg::COND_GE_ZERO: met = ~is_neg(rs_val);
            bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE: met = coprocessor_zero_class_cond;
            bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE: met = ~coprocessor_zero_class_cond;
            bru_pkg::COND_JUMP: met = 1'b1;
            // unused selector codes never take a branch
            default: met = 1'b0;
        endcase
    end

endmodule

/* design/bru_map.svh */
// Behaviour
// - a conditional branch target, other than on coprocessor 0 forms, is the delay-slot address plus the offset shifted left two and sign-extended to 64 bits.
// - ordinary branch forms never suppress the delay-slot instruction.
// - a likely form whose condition is false nullifies its delay-slot instruction.
// - the target fetch is requested while the branch sits in the execute stage.
// - compare and target sum span late register-read and early execute, so results show one cycle after the branch is taken in.
// - jumps also have exactly one delay slot and never nullify it.
// - the equal branch is taken on equal sources, the not-equal branch on differing sources.
// - the le-zero and gt-zero branches test the source against zero and are taken when the test holds.
// - the lt-zero and ge-zero branches test the source against zero and are taken when the test holds.
// - linking zero-compare forms write the address after the delay slot into r31.
// - coprocessor 0 branches follow the condition signal, true or false form, with the target summed in 32 bits and sign-extended to 64.
// - likely variants use the ordinary conditions and discard the slot when not taken.
`ifndef BRU_MAP_SVH
`define BRU_MAP_SVH

// ****************************************
// widths
// ****************************************
`define BRU_XLEN 64
`define BRU_OFF_W 16
`define BRU_NARROW_W 32
`define BRU_REG_W 5

// ****************************************
// address arithmetic
// ****************************************
`define BRU_OFF_SHIFT 2
`define BRU_INSN_BYTES 64'h4
`define BRU_LINK_REG 5'h1f

// ****************************************
// reset values
// ****************************************
`define BRU_RST_ADDR 64'h0
`define BRU_RST_REG 5'h0

`endif

/* design/bru_pkg.sv */
package bru_pkg;

    // ****************************************
    // branch condition selector
    // ****************************************
    typedef enum logic [3:0] {
        COND_EQUAL,
        COND_NOT_EQUAL,
        COND_LE_ZERO,
        COND_GT_ZERO,
        COND_LT_ZERO,
        COND_GE_ZERO,
        COND_COPROCESSOR_ZERO_CLASS_TRUE,
        COND_COPROCESSOR_ZERO_CLASS_FALSE,
        COND_JUMP
    } bru_cond_t;

    // ****************************************
    // delay-slot tracker
    // ****************************************
    typedef enum logic {
        ST_IDLE,
        ST_SLOT
    } bru_state_t;

endpackage

/* design/bru_top.sv */
`timescale 1ns/1ps
`include "bru_map.svh"
module bru_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic STALL,
    input wire logic RF_VALID,
    input wire bru_pkg::bru_cond_t RF_COND,
    input wire logic RF_LIKELY,
    input wire logic RF_LINK,
    input wire logic [`BRU_XLEN-1:0] RF_RS_VAL,
    input wire logic [`BRU_XLEN-1:0] RF_RT_VAL,
    input wire logic [`BRU_OFF_W-1:0] RF_OFFSET,
    input wire logic [`BRU_XLEN-1:0] RF_SLOT_PC,
    input wire logic [`BRU_XLEN-1:0] RF_JUMP_TARGET,
    input wire logic COPROCESSOR_ZERO_CLASS_COND,
    output logic EX_VALID,
    output logic EX_TAKEN,
    output logic EX_FETCH_REQ,
    output logic [`BRU_XLEN-1:0] EX_FETCH_ADDR,
    output logic EX_SLOT_NULLIFY,
    output logic EX_LINK_WE,
    output logic [`BRU_REG_W-1:0] EX_LINK_REG,
    output logic [`BRU_XLEN-1:0] EX_LINK_ADDR,
    output logic EX_IS_SLOT
);

    // ****************************************
    // address helpers
    // ****************************************
    function automatic logic [`BRU_XLEN-1:0] off_wide(input logic [`BRU_OFF_W-1:0] off);
        return {{(`BRU_XLEN-`BRU_OFF_W-`BRU_OFF_SHIFT){off[`BRU_OFF_W-1]}},
                off, {`BRU_OFF_SHIFT{1'b0}}};
    endfunction

    // coprocessor_zero_class branches form a 32-bit address, then widen it by its own sign
    function automatic logic [`BRU_XLEN-1:0] coprocessor_zero_class_target(
        input logic [`BRU_XLEN-1:0] slot_pc,
        input logic [`BRU_OFF_W-1:0] off
    );
        logic [`BRU_XLEN-1:0] wide;
        logic [`BRU_NARROW_W-1:0] sum;
        wide = off_wide(off);
        sum = slot_pc[`BRU_NARROW_W-1:0] + wide[`BRU_NARROW_W-1:0];
        return {{(`BRU_XLEN-`BRU_NARROW_W){sum[`BRU_NARROW_W-1]}}, sum};
    endfunction

    function automatic logic is_branch(input bru_pkg::bru_cond_t c);
        return c != bru_pkg::COND_JUMP;
    endfunction

    // ****************************************
    // condition evaluation, late register-read
    // ****************************************
    logic cond_met;
    logic rf_take;
    logic is_jump;
    logic is_coprocessor_zero_class;
    logic link_ok;
    logic [`BRU_XLEN-1:0] target;

    bru_cond u_cond (
        .cond(RF_COND),
        .rs_val(RF_RS_VAL),
        .rt_val(RF_RT_VAL),
        .coprocessor_zero_class_cond(COPROCESSOR_ZERO_CLASS_COND),
        .met(cond_met)
    );

    always_comb begin
        rf_take = RF_VALID & ~STALL & ~RST;
        is_jump = ~is_branch(RF_COND);
        is_coprocessor_zero_class = (RF_COND == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE) |
                  (RF_COND == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE);
        // link only exists on the lt/ge zero forms and on jumps
        link_ok = RF_LINK & ((RF_COND == bru_pkg::COND_LT_ZERO) |
                             (RF_COND == bru_pkg::COND_GE_ZERO) | is_jump);
        if (is_jump) begin
            target = RF_JUMP_TARGET;
        end else if (is_coprocessor_zero_class) begin
            target = coprocessor_zero_class_target(RF_SLOT_PC, RF_OFFSET);
        end else begin
            target = RF_SLOT_PC + off_wide(RF_OFFSET);
        end
    end

    // ****************************************
    // register-read to execute boundary
    // ****************************************
    logic ex_valid_q, ex_valid_d;
    logic ex_taken_q, ex_taken_d;
    logic ex_fetch_q, ex_fetch_d;
    logic [`BRU_XLEN-1:0] ex_addr_q, ex_addr_d;
    logic ex_null_q, ex_null_d;
    logic ex_link_we_q, ex_link_we_d;
    logic [`BRU_REG_W-1:0] ex_link_reg_q, ex_link_reg_d;
    logic [`BRU_XLEN-1:0] ex_link_addr_q, ex_link_addr_d;
    logic ex_slot_q, ex_slot_d;
    bru_pkg::bru_state_t state_q, state_d;

    always_comb begin
        ex_valid_d = ex_valid_q;
        ex_taken_d = ex_taken_q;
        ex_fetch_d = ex_fetch_q;
        ex_addr_d = ex_addr_q;
        ex_null_d = ex_null_q;
        ex_link_we_d = ex_link_we_q;
        ex_link_reg_d = ex_link_reg_q;
        ex_link_addr_d = ex_link_addr_q;
        ex_slot_d = ex_slot_q;
        state_d = state_q;
        // a stall freezes execute so the fetch redirect is held, not lost
        if (!STALL) begin
            ex_valid_d = RF_VALID;
            ex_taken_d = RF_VALID & cond_met;
            ex_fetch_d = RF_VALID & cond_met;
            ex_addr_d = target;
            // only a failing likely branch kills its slot
            ex_null_d = RF_VALID & RF_LIKELY & ~is_jump & ~cond_met;
            ex_link_we_d = RF_VALID & link_ok;
            ex_link_reg_d = link_ok ? `BRU_LINK_REG : `BRU_RST_REG;
            ex_link_addr_d = RF_SLOT_PC + `BRU_INSN_BYTES;
            ex_slot_d = RF_VALID & (state_q == bru_pkg::ST_SLOT);
            if (RF_VALID) begin
                unique case (state_q)
                    bru_pkg::ST_IDLE: begin
                        // every branch or jump owns exactly one slot
                        state_d = bru_pkg::ST_SLOT;
                    end
                    bru_pkg::ST_SLOT: begin
                        // a branch placed in a slot gets no slot of its own
                        state_d = bru_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ex_valid_q <= 1'b0;
            ex_taken_q <= 1'b0;
            ex_fetch_q <= 1'b0;
            ex_addr_q <= `BRU_RST_ADDR;
            ex_null_q <= 1'b0;
            ex_link_we_q <= 1'b0;
            ex_link_reg_q <= `BRU_RST_REG;
            ex_link_addr_q <= `BRU_RST_ADDR;
            ex_slot_q <= 1'b0;
            state_q <= bru_pkg::ST_IDLE;
        end else begin
            ex_valid_q <= ex_valid_d;
            ex_taken_q <= ex_taken_d;
            ex_fetch_q <= ex_fetch_d;
            ex_addr_q <= ex_addr_d;
            ex_null_q <= ex_null_d;
            ex_link_we_q <= ex_link_we_d;
            ex_link_reg_q <= ex_link_reg_d;
            ex_link_addr_q <= ex_link_addr_d;
            ex_slot_q <= ex_slot_d;
            state_q <= state_d;
        end
    end

    assign EX_VALID = ex_valid_q;
    assign EX_TAKEN = ex_taken_q;
    assign EX_FETCH_REQ = ex_fetch_q;
    assign EX_FETCH_ADDR = ex_addr_q;
    assign EX_SLOT_NULLIFY = ex_null_q;
    assign EX_LINK_WE = ex_link_we_q;
    assign EX_LINK_REG = ex_link_reg_q;
    assign EX_LINK_ADDR = ex_link_addr_q;
    assign EX_IS_SLOT = ex_slot_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    logic [`BRU_XLEN-1:0] chk_off;
    logic chk_plain;
    logic chk_coprocessor_zero_class_t;
    assign chk_off = {{46{RF_OFFSET[15]}}, RF_OFFSET, 2'h0};
    assign chk_plain = rf_take & (RF_COND inside {bru_pkg::COND_EQUAL,
        bru_pkg::COND_NOT_EQUAL, bru_pkg::COND_LE_ZERO, bru_pkg::COND_GT_ZERO,
        bru_pkg::COND_LT_ZERO, bru_pkg::COND_GE_ZERO});
    assign chk_coprocessor_zero_class_t = rf_take & (RF_COND == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE);

    a_target_sum: assert property (
        chk_plain |=> EX_FETCH_ADDR == $past(RF_SLOT_PC) + $past(chk_off))
        else $error("branch target not slot address plus offset");

    a_slot_kept: assert property (
        rf_take && !RF_LIKELY |=> !EX_SLOT_NULLIFY)
        else $error("ordinary branch nullified its slot");

    a_likely_null: assert property (
        rf_take && RF_LIKELY && RF_COND != bru_pkg::COND_JUMP
        |=> EX_SLOT_NULLIFY == !EX_TAKEN)
        else $error("likely slot nullify does not mirror outcome");

    a_fetch_in_ex: assert property (
        EX_FETCH_REQ |-> EX_VALID && EX_TAKEN)
        else $error("target fetch outside a taken branch in execute");

    a_one_cycle: assert property (
        rf_take ##1 !STALL |-> EX_VALID ##1 (EX_VALID == $past(RF_VALID)))
        else $error("branch result not one cycle after register read");

    a_jump_slot: assert property (
        rf_take && RF_COND == bru_pkg::COND_JUMP
        |=> EX_TAKEN && !EX_SLOT_NULLIFY && EX_FETCH_ADDR == $past(RF_JUMP_TARGET))
        else $error("jump lost its single delay slot");

    a_equal_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_EQUAL
        |=> EX_TAKEN == ($past(RF_RS_VAL) == $past(RF_RT_VAL)))
        else $error("equal branch outcome wrong");

    a_gtz_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_GT_ZERO
        |=> EX_TAKEN == ($signed($past(RF_RS_VAL)) > 0))
        else $error("gt-zero branch outcome wrong");

    a_ltz_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_LT_ZERO
        |=> EX_TAKEN == ($signed($past(RF_RS_VAL)) < 0))
        else $error("lt-zero branch outcome wrong");

    a_link_write: assert property (
        rf_take && RF_LINK && RF_COND == bru_pkg::COND_GE_ZERO
        |=> EX_LINK_WE && EX_LINK_REG == 5'h1f
            && EX_LINK_ADDR == $past(RF_SLOT_PC) + 64'h4)
        else $error("link branch did not write r31 with slot address plus 4");

    a_coprocessor_zero_class_true: assert property (
        chk_coprocessor_zero_class_t |=> EX_TAKEN == $past(COPROCESSOR_ZERO_CLASS_COND)
            && EX_FETCH_ADDR[63:31] == {33{EX_FETCH_ADDR[31]}})
        else $error("coprocessor_zero_class branch outcome or 32-bit target wrong");

    a_likely_same: assert property (
        rf_take && RF_LIKELY && RF_COND == bru_pkg::COND_NOT_EQUAL
        |=> EX_TAKEN == ($past(RF_RS_VAL) != $past(RF_RT_VAL)))
        else $error("likely branch uses a different condition");

    a_lez_zero: assert property (
        rf_take && RF_COND == bru_pkg::COND_LE_ZERO && RF_RS_VAL == 64'h0 |=> EX_TAKEN)
        else $error("le-zero not taken on zero source");

    a_stall_hold: assert property (
        STALL |=> $stable(EX_FETCH_ADDR) && $stable(EX_VALID))
        else $error("execute stage moved during stall");

    a_ne_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_NOT_EQUAL
        |=> EX_TAKEN == ($past(RF_RS_VAL) != $past(RF_RT_VAL)))
        else $error("not-equal branch outcome wrong");

    a_lez_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_LE_ZERO
        |=> EX_TAKEN == ($signed($past(RF_RS_VAL)) <= 0))
        else $error("le-zero branch outcome wrong");

    a_gez_cmp: assert property (
        rf_take && RF_COND == bru_pkg::COND_GE_ZERO
        |=> EX_TAKEN == ($signed($past(RF_RS_VAL)) >= 0))
        else $error("ge-zero branch outcome wrong");

    a_coprocessor_zero_class_false: assert property (
        rf_take && RF_COND == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE
        |=> EX_TAKEN == !$past(COPROCESSOR_ZERO_CLASS_COND))
        else $error("coprocessor_zero_class false branch outcome wrong");

    a_coprocessor_zero_class_low: assert property (
        rf_take && RF_COND inside {bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE, bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE}
        |=> EX_FETCH_ADDR[31:0] == $past(RF_SLOT_PC[31:0]) + $past(chk_off[31:0]))
        else $error("coprocessor_zero_class branch low target word wrong");

    a_idle_clear: assert property (
        !STALL && !RF_VALID
        |=> !EX_VALID && !EX_TAKEN && !EX_FETCH_REQ && !EX_SLOT_NULLIFY && !EX_LINK_WE)
        else $error("execute flags left set after an empty register-read cycle");

    a_slot_mark: assert property (
        rf_take && EX_VALID && !EX_IS_SLOT |=> EX_IS_SLOT)
        else $error("instruction after a branch not marked as its delay slot");

    a_slot_end: assert property (
        rf_take && EX_IS_SLOT |=> !EX_IS_SLOT)
        else $error("delay slot opened a second slot");

    a_link_off: assert property (
        rf_take && RF_COND == bru_pkg::COND_EQUAL |=> !EX_LINK_WE && EX_LINK_REG == 5'h0)
        else $error("non-linking branch wrote the link register");

    c_coprocessor_zero_class_taken: cover property (chk_coprocessor_zero_class_t ##1 EX_TAKEN);
    c_taken_branch: cover property (rf_take && chk_plain ##1 EX_TAKEN);
    c_likely_kill: cover property (rf_take && RF_LIKELY ##1 EX_SLOT_NULLIFY);
    c_link_write: cover property (EX_LINK_WE && EX_TAKEN);
    c_slot_follow: cover property (EX_FETCH_REQ ##1 EX_IS_SLOT);

endmodule

/* verif/bru_far_model.sv */
`timescale 1ns/1ps
module bru_far_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic coprocessor_zero_class_src,
    input wire logic link_we,
    input wire logic [4:0] link_reg,
    input wire logic [63:0] link_addr,
    output logic coprocessor_zero_class_cond,
    output logic [63:0] r31_q
);
    // ****************************************
    // coprocessor_zero_class flag and link register
    // ****************************************
    // coprocessor_zero_class flag is a plain level on the same clock, so no sync stage here
    assign coprocessor_zero_class_cond = coprocessor_zero_class_src;
    // only r31 is kept: other targets would hide a wrong link index
    always_ff @(posedge mclk) begin
        if (rst) begin
            r31_q <= 64'h0;
        end else if (link_we && link_reg == 5'h1f) begin
            r31_q <= link_addr;
        end
    end
endmodule

/* verif/test_branch_resolution_unit.sv */
`timescale 1ns/1ps
module test_branch_resolution_unit;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic stall = 1'b0;
    logic rf_valid = 1'b0;
    bru_pkg::bru_cond_t rf_cond = bru_pkg::COND_EQUAL;
    logic rf_likely = 1'b0;
    logic rf_link = 1'b0;
    logic [63:0] rs = 64'h0, rt = 64'h0, slot = 64'h0, jt = 64'h0;
    logic [15:0] off = 16'h0;
    logic coprocessor_zero_class_set = 1'b0;
    logic coprocessor_zero_class;
    logic ex_valid, ex_taken, ex_req, ex_null, ex_we, ex_slot;
    logic [4:0] ex_reg;
    logic [63:0] ex_addr, ex_laddr, r31;
    int miscompares = 0;
    int num_checks = 0;
    logic prev_br = 1'b0;
    logic [63:0] vals [5] = '{64'h0, 64'h1, '1, 64'h8000_0000_0000_0000, 64'h7fff_ffff_ffff_ffff};

    always #20 mclk = ~mclk;

    bru_top DUT (.MCLK(mclk), .RST(rst), .STALL(stall), .RF_VALID(rf_valid), .RF_COND(rf_cond),
        .RF_LIKELY(rf_likely), .RF_LINK(rf_link), .RF_RS_VAL(rs), .RF_RT_VAL(rt),
        .RF_OFFSET(off), .RF_SLOT_PC(slot), .RF_JUMP_TARGET(jt), .COPROCESSOR_ZERO_CLASS_COND(coprocessor_zero_class),
        .EX_VALID(ex_valid), .EX_TAKEN(ex_taken), .EX_FETCH_REQ(ex_req), .EX_FETCH_ADDR(ex_addr),
        .EX_SLOT_NULLIFY(ex_null), .EX_LINK_WE(ex_we), .EX_LINK_REG(ex_reg),
        .EX_LINK_ADDR(ex_laddr), .EX_IS_SLOT(ex_slot));
    bru_far_model far (.mclk(mclk), .rst(rst), .coprocessor_zero_class_src(coprocessor_zero_class_set), .link_we(ex_we),
        .link_reg(ex_reg), .link_addr(ex_laddr), .coprocessor_zero_class_cond(coprocessor_zero_class), .r31_q(r31));

    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic want(input bru_pkg::bru_cond_t c, input logic [63:0] a,
        input logic [63:0] b, input logic cp);
        case (c)
            bru_pkg::COND_EQUAL: return a == b;
            bru_pkg::COND_NOT_EQUAL: return a != b;
            bru_pkg::COND_LE_ZERO: return a[63] || a == 64'h0;
            bru_pkg::COND_GT_ZERO: return !a[63] && a != 64'h0;
            bru_pkg::COND_LT_ZERO: return a[63];
            bru_pkg::COND_GE_ZERO: return !a[63];
            bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE: return cp;
            bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE: return !cp;
            default: return 1'b1;
        endcase
    endfunction

    // one instruction per call; outputs judged one edge later
    task issue(input bru_pkg::bru_cond_t c, input logic lk, input logic ln, input logic [63:0] a,
        input logic [63:0] b, input logic [15:0] o, input logic [63:0] s, input logic cp);
        logic tk;
        logic we;
        logic jmp;
        logic [31:0] lo;
        logic [63:0] tg;
        @(negedge mclk);
        rf_valid = 1'b1;
        rf_cond = c;
        rf_likely = lk;
        rf_link = ln;
        rs = a;
        rt = b;
        off = o;
        slot = s;
        jt = s + 64'h1000;
        coprocessor_zero_class_set = cp;
        tk = want(c, a, b, cp);
        jmp = c == bru_pkg::COND_JUMP;
        lo = s[31:0] + {{14{o[15]}}, o, 2'b00};
        tg = s + {{46{o[15]}}, o, 2'b00};
        if (c == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE || c == bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE) begin
            tg = {{32{lo[31]}}, lo};
        end
        if (jmp) begin
            tg = jt;
        end
        we = ln && (jmp || c == bru_pkg::COND_LT_ZERO || c == bru_pkg::COND_GE_ZERO);
        @(posedge mclk);
        #1;
        chk(ex_valid, 1'b1);
        chk(ex_taken, tk);
        chk(ex_req, tk);
        chk(ex_addr, tg);
        chk(ex_null, lk && !tk && !jmp);
        chk(ex_we, we);
        chk(ex_reg, we ? 64'h1f : 64'h0);
        if (we) begin
            chk(ex_laddr, s + 64'h4);
        end
        chk(ex_slot, prev_br);
        prev_br = !prev_br;
    endtask

    task bubble;
        @(negedge mclk);
        rf_valid = 1'b0;
        @(posedge mclk);
        #1;
        chk({ex_valid, ex_taken, ex_req, ex_null, ex_we}, 64'h0);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_zero;
        bru_pkg::bru_cond_t cz [4] = '{bru_pkg::COND_LE_ZERO, bru_pkg::COND_GT_ZERO,
            bru_pkg::COND_LT_ZERO, bru_pkg::COND_GE_ZERO};
        for (int c = 0; c < 4; c++) begin
            for (int v = 0; v < 10; v++) begin
                issue(cz[c], v[0], 1'b0, vals[v/2], 64'h0, 16'h0004, 64'h100, 1'b0);
            end
        end
        $display("zero compare test done");
    endtask

    task t_equal;
        for (int v = 0; v < 20; v++) begin
            issue(v[0] ? bru_pkg::COND_NOT_EQUAL : bru_pkg::COND_EQUAL, v[1], 1'b0,
                vals[v/4], vals[v/4] ^ (v[2] ? 64'h8000_0000_0000_0000 : 64'h0),
                16'hfff0, 64'h2000, 1'b0);
        end
        $display("equality test done");
    endtask

    task automatic t_target;
        logic [15:0] offs [4] = '{16'h0001, 16'h7fff, 16'h8000, 16'hffff};
        logic [63:0] pcs [3] = '{64'h100, '1 - 64'h3, 64'h7fff_fff0};
        bru_pkg::bru_cond_t ct [3] = '{bru_pkg::COND_EQUAL, bru_pkg::COND_COPROCESSOR_ZERO_CLASS_TRUE,
            bru_pkg::COND_COPROCESSOR_ZERO_CLASS_FALSE};
        for (int i = 0; i < 72; i++) begin
            issue(ct[i%3], i[0], 1'b0, 64'h5, 64'h5, offs[(i/6)%4], pcs[i/24], i[1]);
        end
        $display("target test done");
    endtask

    task automatic t_link;
        bru_pkg::bru_cond_t cl [4] = '{bru_pkg::COND_LT_ZERO, bru_pkg::COND_GE_ZERO,
            bru_pkg::COND_JUMP, bru_pkg::COND_EQUAL};
        for (int i = 0; i < 16; i++) begin
            issue(cl[i/4], i[0], 1'b1, i[1] ? '1 : 64'h0, 64'h1, 16'h0010, 64'h4000 + i * 8, 1'b0);
            bubble();
            if (i < 12) begin
                chk(r31, 64'h4004 + i * 8);
            end
        end
        $display("link test done");
    endtask

    task t_stall;
        issue(bru_pkg::COND_EQUAL, 1'b0, 1'b0, 64'h9, 64'h9, 16'h0002, 64'h100, 1'b0);
        @(negedge mclk);
        stall = 1'b1;
        rf_cond = bru_pkg::COND_NOT_EQUAL;
        slot = 64'h800;
        repeat (3) @(posedge mclk);
        #1;
        chk({ex_valid, ex_taken, ex_req, ex_null}, 64'he);
        chk(ex_addr, 64'h108);
        @(negedge mclk);
        stall = 1'b0;
        rf_valid = 1'b0;
        bubble();
        issue(bru_pkg::COND_GT_ZERO, 1'b1, 1'b0, 64'h0, 64'h0, 16'h0, 64'h100, 1'b0);
        $display("stall test done");
    endtask

    initial begin
        #2_000_000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge mclk);
        #1;
        chk({ex_valid, ex_taken, ex_req, ex_null, ex_we, ex_slot, ex_reg}, 64'h0);
        chk(ex_addr | ex_laddr, 64'h0);
        @(negedge mclk);
        rst = 1'b0;
        t_zero();
        t_equal();
        t_target();
        t_link();
        t_stall();
        stop_test();
    end
endmodule
